// ===== rtl/pwt_chan.sv
/*
 * One duty channel: compare against the time base and produce the
 * even/odd output pair, with dead time in complementary mode.
 * Assumes duty and counter values come from the same clock domain.
 */
module pwt_chan
  import pwt_pkg::*;
(
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  input  wire logic [CW-1:0] cnt_i,
  input  wire logic [CW-1:0] duty_i,
  input  wire logic          comp_en_i,
  input  wire logic [5:0]    dead_i,
  output logic               even_o,
  output logic               odd_o,
  output logic               match_o
);
  typedef struct packed {
    logic       raw;
    logic [5:0] dt;
    logic       even;
    logic       odd;
  } pwt_chan_st_t;

  pwt_chan_st_t st_ff;
  pwt_chan_st_t nxt_st;
  logic         raw;

  always_comb begin
    nxt_st = st_ff;
    // (RL16) Fixed low and high codes
    if (duty_i == RST_VAL) begin
      raw = 1'b0;
    end else if (duty_i == CNT_MAX) begin
      raw = 1'b1;
    end else begin
      // (RL15) Compare above counter
      raw = duty_i > cnt_i;
    end
    nxt_st.raw = raw;
    // (RL2) Dead time on each edge
    if (raw != st_ff.raw) begin
      nxt_st.dt = dead_i;
    end else if (st_ff.dt != 6'h00) begin
      nxt_st.dt = st_ff.dt - 6'h01;
    end
    if (comp_en_i) begin
      nxt_st.even = st_ff.raw & (st_ff.dt == 6'h00);
      nxt_st.odd  = ~st_ff.raw & (st_ff.dt == 6'h00);
    end else begin
      nxt_st.even = st_ff.raw;
      nxt_st.odd  = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign even_o  = st_ff.even;
  assign odd_o   = st_ff.odd;
  assign match_o = cnt_i == duty_i;

  // (RL16) zero code never drives high
  a_zero_low: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL16
    duty_i == RST_VAL |=> !st_ff.raw)
    else $error("zero compare gave high level");
endmodule : pwt_chan

// ===== rtl/pwt_pkg.sv
/*
 * Constants, register map and carrier types of the PWM time base.
 * Assumes one 40 MHz clock and an AXI4-Lite master on the register side.
 */
//------------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------------
// Summary of operation
// (RL1) 12-bit up/down counter behind a prescaler
// (RL2) Four channels, independent or complementary dead-timed
// (RL3) Edge, center and single shot counting
// (RL4) Counter event and brake interrupt requests
// (RL5) Per-output invert bit flips pin level
// (RL6) Load bit transfers holding values, self-clears
// (RL7) Run bit starts or idles the modulator
// (RL8) Brake forces outputs to brake state levels
// (RL9) Brake enable alone gives software brake
// (RL10) Brake-on-halt brakes while run is low
// (RL11) Pin brakes when level equals polarity bit
// (RL12) Pin brake clears run, sets brake flag
// (RL13) Halt plus pin enable: flag only
// (RL14) Brake release restores pre-brake output levels
// (RL15) Output high when compare exceeds counter
// (RL16) Compare zero always low, all ones high
// (RL17) Period writes go to a holding register
// (RL18) Software resume sequence after pin brake
// (RL19) Values are 12 bits: nibble plus byte
// (RL20) Brake flag sticky until software clears it
package pwt_pkg;

  localparam int CW = 12;
  localparam logic [CW-1:0] CNT_MAX = 12'hfff;

  // Register byte offsets
  localparam logic [7:0] OFS_RUN_LOAD = 8'h00;
  localparam logic [7:0] OFS_BRK_CTL  = 8'h04;
  localparam logic [7:0] OFS_BRK_ST   = 8'h08;
  localparam logic [7:0] OFS_MODE_FLG = 8'h0c;
  localparam logic [7:0] OFS_INVERT   = 8'h10;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h14;
  localparam logic [7:0] OFS_DEAD     = 8'h18;
  localparam logic [7:0] OFS_PERIOD   = 8'h1c;
  localparam logic [7:0] OFS_CMP0     = 8'h20;
  localparam logic [7:0] OFS_STATUS   = 8'h30;

  // Field positions
  localparam int B_RUN    = 7;
  localparam int B_LOAD   = 6;
  localparam int B_PSEL   = 4;
  localparam int B_MODE   = 0;
  localparam int B_HALT   = 7;
  localparam int B_POL    = 6;
  localparam int B_PINEN  = 5;
  localparam int B_BRKEN  = 4;
  localparam int B_BKFLAG = 0;
  localparam int B_CNTFLG = 1;
  localparam int B_COMPEN = 4;

  // Reset values
  localparam logic [7:0]    RST_BYTE = 8'h00;
  localparam logic [CW-1:0] RST_VAL  = 12'h000;
  localparam logic [5:0]    RST_DEAD = 6'h00;

  // Prescaler last counts for divide by 1, 2, 4, 16
  localparam logic [3:0] PRE_D1  = 4'h0;
  localparam logic [3:0] PRE_D2  = 4'h1;
  localparam logic [3:0] PRE_D4  = 4'h3;
  localparam logic [3:0] PRE_D16 = 4'hf;

  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_EDGE,
    MODE_CENTER,
    MODE_SINGLE,
    MODE_RSVD
  } pwt_mode_t;

  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } pwt_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pwt_axi_rsp_t;

endpackage : pwt_pkg

// ===== rtl/pwt_sync.sv
/*
 * Two-stage synchroniser for asynchronous pin levels.
 * Assumes the input may change at any time relative to clk_i.
 */
module pwt_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pwt_sync_st_t;

  pwt_sync_st_t st_ff;
  pwt_sync_st_t nxt_st;

  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = d_i;
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q_o = st_ff.s2;
endmodule : pwt_sync

// ===== rtl/pwt_top.sv
/*
 * PWM time base with brake control behind an AXI4-Lite slave.
 * Assumes an asynchronous brake pin and one 40 MHz clock.
 */
module pwt_top
  import pwt_pkg::*;
(
  input  wire logic         CLOCK_I,
  input  wire logic         RST_N_I,
  input  wire pwt_axi_req_t S_AXI_REQ_I,
  output pwt_axi_rsp_t      S_AXI_RSP_O,
  input  wire logic         BRAKE_PIN_I,
  output logic [7:0]        PWM_O,
  output logic              IRQ_CNT_O,
  output logic              IRQ_BRK_O
);
  //------------------------------------------------------------------
  // State
  //------------------------------------------------------------------
  typedef struct packed {
    logic                aw_have;
    logic [7:0]          awaddr;
    logic                w_have;
    logic [31:0]         wdata;
    logic [3:0]          wstrb;
    pwt_axi_rsp_t        rsp;
    logic                run;
    logic                load;
    logic [1:0]          psel;
    pwt_mode_t           mode;
    logic                halt;
    logic                pol;
    logic                pinen;
    logic                brken;
    logic [7:0]          bstate;
    logic                flag_brk;
    logic                flag_cnt;
    logic [3:0]          comp_en;
    logic [7:0]          inv;
    logic [1:0]          ie;
    logic [5:0]          dead;
    logic [CW-1:0]       per_h;
    logic [3:0][CW-1:0]  cmp_h;
    logic [CW-1:0]       per_a;
    logic [3:0][CW-1:0]  cmp_a;
    logic [CW-1:0]       cnt;
    logic                dn;
    logic [3:0]          pre;
    logic [7:0]          pwm;
    logic                irq_c;
    logic                irq_b;
  } pwt_st_t;

  pwt_st_t    st_ff;
  pwt_st_t    nxt_st;
  logic       pin_s;
  logic [3:0] ch_even;
  logic [3:0] ch_odd;
  logic [3:0] ch_match;
  logic [7:0] norm;
  logic       pin_act;
  logic       sw_brk;
  logic       halt_brk;
  logic       pin_brk;
  logic       brake;

  //------------------------------------------------------------------
  // Pin synchroniser and channels
  //------------------------------------------------------------------
  pwt_sync #(.W(1)) u_sync (
    .clk_i   (CLOCK_I),
    .rst_n_i (RST_N_I),
    .d_i     (BRAKE_PIN_I),
    .q_o     (pin_s)
  );

  // (RL2) Four duty generators
  for (genvar g = 0; g < 4; g++) begin : g_ch
    pwt_chan u_ch (
      .clk_i     (CLOCK_I),
      .rst_n_i   (RST_N_I),
      .cnt_i     (st_ff.cnt),
      .duty_i    (st_ff.cmp_a[g]),
      .comp_en_i (st_ff.comp_en[g]),
      .dead_i    (st_ff.dead),
      .even_o    (ch_even[g]),
      .odd_o     (ch_odd[g]),
      .match_o   (ch_match[g])
    );
    // (RL5) Invert per output
    assign norm[2*g]   = ch_even[g] ^ st_ff.inv[2*g];
    assign norm[2*g+1] = ch_odd[g] ^ st_ff.inv[2*g+1];
  end

  //------------------------------------------------------------------
  // Brake sources
  //------------------------------------------------------------------
  // (RL11) Pin matches polarity
  assign pin_act  = pin_s == st_ff.pol;
  // (RL9) Software brake
  assign sw_brk   = st_ff.brken & ~st_ff.halt & ~st_ff.pinen;
  // (RL10) Brake on halt
  assign halt_brk = st_ff.brken & st_ff.halt & ~st_ff.run;
  // (RL13) Pin brakes only without halt bit
  assign pin_brk  = st_ff.brken & st_ff.pinen & ~st_ff.halt & pin_act;
  assign brake    = sw_brk | halt_brk | pin_brk;

  //------------------------------------------------------------------
  // Next state
  //------------------------------------------------------------------
  always_comb begin
    logic [3:0]    last;
    logic          tick;
    logic          bound;
    logic          unf;
    logic          wr;
    logic [5:0]    widx;
    logic [5:0]    ridx;
    logic [31:0]   rd;
    logic          rok;
    last  = PRE_D1;
    tick  = 1'b0;
    bound = 1'b0;
    unf   = 1'b0;
    wr    = 1'b0;
    widx  = st_ff.awaddr[7:2];
    ridx  = S_AXI_REQ_I.araddr[7:2];
    rd    = 32'h0000_0000;
    rok   = 1'b1;
    nxt_st = st_ff;

    // Bus handshake: address and data accepted in either order
    if (S_AXI_REQ_I.awvalid && st_ff.rsp.awready) begin
      nxt_st.aw_have = 1'b1;
      nxt_st.awaddr  = S_AXI_REQ_I.awaddr;
    end
    if (S_AXI_REQ_I.wvalid && st_ff.rsp.wready) begin
      nxt_st.w_have = 1'b1;
      nxt_st.wdata  = S_AXI_REQ_I.wdata;
      nxt_st.wstrb  = S_AXI_REQ_I.wstrb;
    end
    if (st_ff.rsp.bvalid && S_AXI_REQ_I.bready) begin
      nxt_st.rsp.bvalid = 1'b0;
    end
    if (st_ff.aw_have && st_ff.w_have && !st_ff.rsp.bvalid) begin
      wr                = 1'b1;
      nxt_st.aw_have    = 1'b0;
      nxt_st.w_have     = 1'b0;
      nxt_st.rsp.bvalid = 1'b1;
      nxt_st.rsp.bresp  = RESP_OK;
    end
    nxt_st.rsp.awready = ~nxt_st.aw_have;
    nxt_st.rsp.wready  = ~nxt_st.w_have;

    // Register writes
    if (wr) begin
      if (widx == OFS_RUN_LOAD[7:2] && st_ff.wstrb[0]) begin
        // (RL7) Run bit
        nxt_st.run  = st_ff.wdata[B_RUN];
        nxt_st.load = st_ff.wdata[B_LOAD];
        nxt_st.psel = st_ff.wdata[B_PSEL +: 2];
        nxt_st.mode = pwt_mode_t'(st_ff.wdata[B_MODE +: 2]);
      end else if (widx == OFS_BRK_CTL[7:2] && st_ff.wstrb[0]) begin
        nxt_st.halt  = st_ff.wdata[B_HALT];
        nxt_st.pol   = st_ff.wdata[B_POL];
        nxt_st.pinen = st_ff.wdata[B_PINEN];
        nxt_st.brken = st_ff.wdata[B_BRKEN];
      end else if (widx == OFS_BRK_ST[7:2] && st_ff.wstrb[0]) begin
        nxt_st.bstate = st_ff.wdata[7:0];
      end else if (widx == OFS_MODE_FLG[7:2] && st_ff.wstrb[0]) begin
        // (RL20) Flags clear only by a one written
        if (st_ff.wdata[B_BKFLAG]) begin
          nxt_st.flag_brk = 1'b0;
        end
        if (st_ff.wdata[B_CNTFLG]) begin
          nxt_st.flag_cnt = 1'b0;
        end
        nxt_st.comp_en = st_ff.wdata[B_COMPEN +: 4];
      end else if (widx == OFS_INVERT[7:2] && st_ff.wstrb[0]) begin
        nxt_st.inv = st_ff.wdata[7:0];
      end else if (widx == OFS_IRQ_EN[7:2] && st_ff.wstrb[0]) begin
        nxt_st.ie = st_ff.wdata[1:0];
      end else if (widx == OFS_DEAD[7:2] && st_ff.wstrb[0]) begin
        nxt_st.dead = st_ff.wdata[5:0];
      end else if (widx == OFS_PERIOD[7:2]) begin
        // (RL17) Period lands in holding register
        // (RL19) Low byte plus low nibble of next byte
        if (st_ff.wstrb[0]) begin
          nxt_st.per_h[7:0] = st_ff.wdata[7:0];
        end
        if (st_ff.wstrb[1]) begin
          nxt_st.per_h[11:8] = st_ff.wdata[11:8];
        end
      end else if (widx[5:2] == OFS_CMP0[7:4]) begin
        if (st_ff.wstrb[0]) begin
          nxt_st.cmp_h[widx[1:0]][7:0] = st_ff.wdata[7:0];
        end
        if (st_ff.wstrb[1]) begin
          nxt_st.cmp_h[widx[1:0]][11:8] = st_ff.wdata[11:8];
        end
      end else begin
        nxt_st.rsp.bresp = RESP_ERR;
      end
    end

    // Read channel: one read in flight, answered the next cycle
    if (st_ff.rsp.rvalid && S_AXI_REQ_I.rready) begin
      nxt_st.rsp.rvalid = 1'b0;
    end
    if (S_AXI_REQ_I.arvalid && st_ff.rsp.arready) begin
      case (ridx)
        OFS_RUN_LOAD[7:2]: rd[7:0] = {st_ff.run, st_ff.load, st_ff.psel,
                                      2'b00, st_ff.mode};
        OFS_BRK_CTL[7:2]:  rd[7:0] = {st_ff.halt, st_ff.pol, st_ff.pinen,
                                      st_ff.brken, 4'h0};
        OFS_BRK_ST[7:2]:   rd[7:0] = st_ff.bstate;
        OFS_MODE_FLG[7:2]: rd[7:0] = {st_ff.comp_en, 2'b00,
                                      st_ff.flag_cnt, st_ff.flag_brk};
        OFS_INVERT[7:2]:   rd[7:0] = st_ff.inv;
        OFS_IRQ_EN[7:2]:   rd[1:0] = st_ff.ie;
        OFS_DEAD[7:2]:     rd[5:0] = st_ff.dead;
        OFS_PERIOD[7:2]:   rd[11:0] = st_ff.per_h;
        OFS_STATUS[7:2]:   rd[13:0] = {brake, st_ff.dn, st_ff.cnt};
        default: begin
          if (ridx[5:2] == OFS_CMP0[7:4]) begin
            rd[11:0] = st_ff.cmp_h[ridx[1:0]];
          end else begin
            rok = 1'b0;
          end
        end
      endcase
      nxt_st.rsp.rvalid = 1'b1;
      nxt_st.rsp.rdata  = rd;
      nxt_st.rsp.rresp  = rok ? RESP_OK : RESP_ERR;
    end
    nxt_st.rsp.arready = ~nxt_st.rsp.rvalid;

    // (RL1) Prescaler: divide by 1, 2, 4 or 16
    case (st_ff.psel)
      2'd0:    last = PRE_D1;
      2'd1:    last = PRE_D2;
      2'd2:    last = PRE_D4;
      default: last = PRE_D16;
    endcase
    // (RL14) Time base frozen while braked keeps pre-brake levels
    tick = st_ff.run && !brake && (st_ff.pre == last);
    nxt_st.pre = (tick || !st_ff.run || brake) ? 4'h0 : st_ff.pre + 4'h1;

    // (RL3) Counting modes
    if (tick) begin
      case (st_ff.mode)
        MODE_CENTER: begin
          if (!st_ff.dn) begin
            if (st_ff.cnt >= st_ff.per_a) begin
              nxt_st.dn  = 1'b1;
              nxt_st.cnt = st_ff.cnt - 12'h001;
            end else begin
              nxt_st.cnt = st_ff.cnt + 12'h001;
            end
          end else if (st_ff.cnt == RST_VAL) begin
            nxt_st.dn  = 1'b0;
            nxt_st.cnt = 12'h001;
            bound      = 1'b1;
            unf        = 1'b1;
          end else begin
            nxt_st.cnt = st_ff.cnt - 12'h001;
          end
        end
        MODE_SINGLE: begin
          if (st_ff.cnt >= st_ff.per_a) begin
            nxt_st.cnt = RST_VAL;
            nxt_st.run = 1'b0;
            bound      = 1'b1;
          end else begin
            nxt_st.cnt = st_ff.cnt + 12'h001;
          end
        end
        default: begin
          if (st_ff.cnt >= st_ff.per_a) begin
            nxt_st.cnt = RST_VAL;
            bound      = 1'b1;
            unf        = 1'b1;
          end else begin
            nxt_st.cnt = st_ff.cnt + 12'h001;
          end
        end
      endcase
    end

    // (RL6) Transfer at period boundary or while idle
    if (st_ff.load && (!st_ff.run || bound)) begin
      nxt_st.per_a = st_ff.per_h;
      nxt_st.cmp_a = st_ff.cmp_h;
      nxt_st.load  = 1'b0;
    end

    // (RL4) Counter event: a set wins over a clear
    if (tick && (unf || (|ch_match))) begin
      nxt_st.flag_cnt = 1'b1;
    end
    // (RL12) Pin brake sets flag, beats a clear
    if (st_ff.brken && st_ff.pinen && pin_act) begin
      nxt_st.flag_brk = 1'b1;
    end
    // (RL12) Pin brake clears run, beats a write
    if (pin_brk) begin
      nxt_st.run = 1'b0;
    end

    // (RL8) Brake forces programmed levels
    nxt_st.pwm   = brake ? st_ff.bstate : norm;
    nxt_st.irq_c = st_ff.flag_cnt & st_ff.ie[0];
    // (RL20) Sticky flag drives brake request
    nxt_st.irq_b = st_ff.flag_brk & st_ff.ie[1];
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_ff             <= '0;
      st_ff.rsp.awready <= 1'b1;
      st_ff.rsp.wready  <= 1'b1;
      st_ff.rsp.arready <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign S_AXI_RSP_O = st_ff.rsp;
  assign PWM_O       = st_ff.pwm;
  assign IRQ_CNT_O   = st_ff.irq_c;
  assign IRQ_BRK_O   = st_ff.irq_b;

  //------------------------------------------------------------------
  // Assertions
  //------------------------------------------------------------------
  // Address and data both held: written unless a response is pending; a register write may drop run
  logic wr_seen;
  assign wr_seen = st_ff.aw_have && st_ff.w_have;

  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);

  a_brake_levels: assert property ( // RL8
    brake |=> PWM_O == $past(st_ff.bstate))
    else $error("braked outputs differ from brake state");
  a_sw_brake: assert property ( // RL9
    st_ff.brken && !st_ff.halt && !st_ff.pinen |=>
    PWM_O == $past(st_ff.bstate))
    else $error("software brake not applied");
  a_halt_brake: assert property ( // RL10
    st_ff.brken && st_ff.halt && !st_ff.run |-> brake)
    else $error("halt brake missing");
  a_pin_stops_run: assert property ( // RL12
    pin_brk |=> !st_ff.run)
    else $error("pin brake left run set");
  a_pin_flag_set: assert property ( // RL12
    st_ff.brken && st_ff.pinen && pin_act |=> st_ff.flag_brk)
    else $error("brake flag not set by pin");
  a_flag_only: assert property ( // RL13
    st_ff.brken && st_ff.halt && st_ff.pinen && st_ff.run |->
    !brake ##1 st_ff.run || $past(wr_seen))
    else $error("flag-only mode braked or stopped");
  a_load_clears: assert property ( // RL6
    st_ff.load && !st_ff.run |=> !st_ff.load && st_ff.per_a ==
    $past(st_ff.per_h))
    else $error("idle load did not transfer");
  a_period_held: assert property ( // RL17
    !$past(st_ff.load) |-> $stable(st_ff.per_a))
    else $error("active period changed without load");
  a_brk_irq: assert property ( // RL4
    st_ff.flag_brk && st_ff.ie[1] |=> IRQ_BRK_O)
    else $error("brake request missing");

  c_pin_brake: cover property (pin_brk ##1 st_ff.flag_brk);
  c_center_turn: cover property (st_ff.mode == MODE_CENTER && $rose(st_ff.dn));
  c_transfer: cover property (st_ff.run && $fell(st_ff.load));
endmodule : pwt_top

// ===== sim/pwm_timebase_brake_control_tb.sv
/*
 * Self-checking bench of the PWM time base with brake control.
 * Assumes pwt_top, its package and the brake source model.
 */
module pwm_timebase_brake_control_tb
  import pwt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] q;
    logic [1:0]  r;
  } pwt_row_t;
  localparam pwt_row_t ROWS [7] = '{
    '{OFS_BRK_ST, 32'h000000a5, 32'h000000a5, RESP_OK},
    '{OFS_INVERT, 32'h0000003c, 32'h0000003c, RESP_OK},
    '{OFS_IRQ_EN, 32'h00000002, 32'h00000002, RESP_OK},
    '{OFS_DEAD,   32'h0000003f, 32'h0000003f, RESP_OK},
    '{OFS_PERIOD, 32'h00000abc, 32'h00000abc, RESP_OK},
    '{8'h24,      32'h00000123, 32'h00000123, RESP_OK},
    '{8'h44,      32'h00000001, 32'h00000000, RESP_ERR}};
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  pwt_axi_req_t req = '0;
  pwt_axi_rsp_t rsp;
  logic         brk_pin, irq_cnt, irq_brk, samp = 1'b0, ovl = 1'b0;
  logic         brk_act = 1'b0, brk_pol = 1'b1;
  logic [3:0]   brk_lag = 4'h0;
  logic [7:0]   pwm, acc_and = 8'hff, acc_or = 8'h00;
  logic [31:0]  rd;
  logic [11:0]  mx;
  logic [1:0]   rr;
  int           n_fail = 0, compares = 0, n;

  always #12.5 clk = ~clk;

  pwt_top dut_u (.CLOCK_I(clk), .RST_N_I(rst_n), .S_AXI_REQ_I(req),
    .S_AXI_RSP_O(rsp), .BRAKE_PIN_I(brk_pin), .PWM_O(pwm),
    .IRQ_CNT_O(irq_cnt), .IRQ_BRK_O(irq_brk));
  pwt_brk_src brk_u (.clk_i(clk), .act_i(brk_act), .pol_i(brk_pol),
    .lag_i(brk_lag), .pin_o(brk_pin));

  always @(negedge clk) begin
    if (samp) begin
      acc_and &= pwm;
      acc_or |= pwm;
      ovl |= pwm[4] & pwm[5];
    end
  end

  //------------------------------------------------------------------
  // Bus and check tasks
  //------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, exp, input string what);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h want %h", $time, what,
               seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk);
    req.awaddr <= a;
    req.awvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) break;
    end
    req.bready <= 1'b0;
    r = rsp.bresp;
  endtask : wr

  task automatic w(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
  endtask : w

  task automatic rdr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    @(posedge clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) break;
    end
    req.rready <= 1'b0;
    d = rsp.rdata;
    r = rsp.rresp;
  endtask : rdr

  task automatic settle();
    repeat (8) @(negedge clk);
  endtask : settle

  task automatic test_done();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  initial begin
    #(25 * 30000);
    n_fail++;
    $display("unexpected at %0t: watchdog expired", $time);
    test_done();
  end

  //------------------------------------------------------------------
  // Main sequence
  //------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      rdr(8'(4 * i), rd, rr);
      chk(rd, 32'h0, "reset value");
    end
    foreach (ROWS[i]) begin
      wr(ROWS[i].a, ROWS[i].d, rr);
      chk(32'(rr), 32'(ROWS[i].r), "write resp");
      rdr(ROWS[i].a, rd, rr);
      chk(32'(rr), 32'(ROWS[i].r), "read resp");
      if (ROWS[i].r === RESP_OK) chk(rd, ROWS[i].q, "readback");
    end
    $display("test registers done");
    // Fixed, inverted and toggling channels under edge counting
    w(OFS_INVERT, 32'h04);
    w(OFS_IRQ_EN, 32'h03);
    w(OFS_PERIOD, 32'h0ff);
    w(OFS_CMP0, 32'hfff);
    w(8'h24, 32'h000);
    w(8'h28, 32'h080);
    w(OFS_RUN_LOAD, 32'hc0);
    n = 0;
    do begin
      rdr(OFS_RUN_LOAD, rd, rr);
      n++;
    end while (rd[B_LOAD] !== 1'b0 && n < 50);
    chk(rd & 32'hc0, 32'h80, "load self clear");
    // Period written without load must not reach the live counter
    w(OFS_PERIOD, 32'h010);
    mx = 12'h000;
    samp = 1'b1;
    repeat (100) begin
      rdr(OFS_STATUS, rd, rr);
      if (rd[11:0] > mx) mx = rd[11:0];
    end
    samp = 1'b0;
    chk(32'(mx > 12'h010), 32'h1, "holding period");
    chk(32'(acc_and & 8'h15), 32'h05, "fixed compares");
    chk(32'(acc_or[4]), 32'h1, "duty toggles");
    chk(32'(irq_cnt), 32'h1, "counter irq");
    w(OFS_IRQ_EN, 32'h02);
    $display("test waveform done");
    w(OFS_BRK_ST, 32'ha5);
    w(OFS_BRK_CTL, 32'h10);
    settle();
    chk(32'(pwm), 32'ha5, "software brake");
    w(OFS_BRK_CTL, 32'h00);
    settle();
    chk(32'(pwm & 8'h05), 32'h05, "pre brake levels");
    w(OFS_BRK_ST, 32'h5a);
    w(OFS_BRK_CTL, 32'h90);
    settle();
    chk(32'(pwm[0]), 32'h1, "halt brake idle");
    w(OFS_RUN_LOAD, 32'h00);
    settle();
    chk(32'(pwm), 32'h5a, "halt brake");
    w(OFS_RUN_LOAD, 32'h80);
    w(OFS_BRK_CTL, 32'h00);
    $display("test software brake done");
    // Pin brake at both polarities, slow contact on the second pass
    for (int p = 1; p >= 0; p--) begin
      @(posedge clk);
      brk_pol <= p[0];
      brk_lag <= p[0] ? 4'h0 : 4'h3;
      w(OFS_BRK_CTL, 32'h30 | (32'(p) << 6));
      settle();
      chk(32'(pwm[0]), 32'h1, "pin idle");
      @(posedge clk);
      brk_act <= 1'b1;
      settle();
      chk(32'(pwm), 32'h5a, "pin brake");
      rdr(OFS_RUN_LOAD, rd, rr);
      chk(rd & 32'h80, 32'h0, "run cleared");
      chk(32'(irq_brk), 32'h1, "brake irq");
      @(posedge clk);
      brk_act <= 1'b0;
      settle();
      rdr(OFS_MODE_FLG, rd, rr);
      chk(rd & 32'h1, 32'h1, "flag sticky");
      w(OFS_BRK_CTL, 32'h10);
      w(OFS_MODE_FLG, 32'h01);
      settle();
      chk(32'(irq_brk), 32'h0, "flag cleared");
      w(OFS_RUN_LOAD, 32'hc0);
      w(OFS_BRK_CTL, 32'h00);
    end
    $display("test pin brake done");
    @(posedge clk);
    brk_pol <= 1'b1;
    w(OFS_BRK_CTL, 32'hf0);
    @(posedge clk);
    brk_act <= 1'b1;
    settle();
    chk(32'(pwm[0]), 32'h1, "flag only output");
    rdr(OFS_RUN_LOAD, rd, rr);
    chk(rd & 32'h80, 32'h80, "flag only run");
    rdr(OFS_MODE_FLG, rd, rr);
    chk(rd & 32'h1, 32'h1, "flag only flag");
    @(posedge clk);
    brk_act <= 1'b0;
    $display("test flag only done");
    // Complementary pair 2 under center counting, short dead time
    w(OFS_BRK_CTL, 32'h00);
    w(OFS_DEAD, 32'h02);
    w(8'h28, 32'h008);
    w(OFS_MODE_FLG, 32'h40);
    w(OFS_RUN_LOAD, 32'hc1);
    settle();
    acc_and = 8'hff;
    acc_or = 8'h00;
    mx = 12'h000;
    samp = 1'b1;
    repeat (30) begin
      rdr(OFS_STATUS, rd, rr);
      mx[0] = mx[0] | rd[12];
    end
    samp = 1'b0;
    chk(32'(mx[0]), 32'h1, "center counts down");
    chk(32'(acc_or[5:4]), 32'h3, "pair toggles");
    chk(32'(acc_and[5:4]), 32'h0, "pair low phases");
    chk(32'(ovl), 32'h0, "pair overlap");
    $display("test complementary done");
    @(posedge clk);
    rst_n <= 1'b0;
    @(negedge clk);
    chk(32'(pwm), 32'h0, "reset outputs");
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rdr(OFS_RUN_LOAD, rd, rr);
    chk(rd, 32'h0, "reset idle");
    $display("test reset done");
    test_done();
  end
endmodule : pwm_timebase_brake_control_tb

// ===== sim/pwt_brk_src.sv
/*
 * Brake signal source on the pin side of the PWM time base.
 * Assumes the bench commands it just after rising clock edges.
 */
module pwt_brk_src (
  input  wire logic       clk_i,
  input  wire logic       act_i,
  input  wire logic       pol_i,
  input  wire logic [3:0] lag_i,
  output logic            pin_o
);
  logic [3:0] cnt_ff = 4'h0;
  logic       lvl_ff = 1'b0;

  // A slow contact follows the command only after lag_i + 1 edges
  always_ff @(posedge clk_i) begin
    if (act_i == lvl_ff) begin
      cnt_ff <= 4'h0;
    end else if (cnt_ff >= lag_i) begin
      lvl_ff <= act_i;
      cnt_ff <= 4'h0;
    end else begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end

  // Idle level is the inverse of the active one, never left floating
  assign pin_o = lvl_ff ? pol_i : ~pol_i;
endmodule : pwt_brk_src
